// ===== hdl/tdtf_top.sv
// telegram selection of a controlled transponder: relay, equal-bit run, default telegram
// assumes all inputs synchronous to clk; failure and power detectors sit outside
`timescale 1ns/1ps
`default_nettype none
`include "tdtf_map.svh"

//Function
// [R01] On a cut cable or a lost signal on the wired input the stored default telegram replaces the relayed one.
// [R02] Directly before the first default telegram a run of 75 to 128 equal bits is sent.
// [R03] The equal-bit run ends within 341 uplink bit periods of the failure becoming stable.
// [R04] Once on the default telegram the device keeps it for the rest of the passage even if the input recovers.
// [R05] A data line held at 0 V with the power-frequency line nominal is a failure, and one of 0.6 to 1.0 ms triggers fallback; the code uses 100 us.
// [R06] Optionally a blocking indication is raised toward the encoder at the start of a passage.
// [R07] While blocking is shown the encoder keeps the current telegram until a set delay has passed.
// [R08] The selected telegram is relayed uncorrupted for as long as blocking is asserted.
// [R09] Blocking may start before the operating flux, and data need only be correct 150 us after that flux.
// [R10] Tele-powering removed for about 10 ms clears the latched default so the next passage relays again; the code clears it after 5 ms.
module tdtf_top #(
    parameter int BIT_DIV = `TDTF_CLK_HZ / `TDTF_BIT_RATE,
    parameter int FAIL_CYC = `TDTF_FAIL_US * `TDTF_CLK_MHZ,
    parameter int POWER_OFF_CYC = `TDTF_POWER_OFF_US * `TDTF_CLK_MHZ,
    parameter int VALID_CYC = `TDTF_VALID_US * `TDTF_CLK_MHZ,
    parameter int BLOCK_CYC = `TDTF_BLOCK_US * `TDTF_CLK_MHZ,
    parameter int RUN_BITS = `TDTF_RUN_BITS,
    parameter int DEF_LEN = `TDTF_DEF_LEN,
    // arbitrary default content; real content is set per installation
    parameter logic [DEF_LEN-1:0] DEF_TELEGRAM = 32'h5A3C_96E1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wired input from the lineside encoder
    input wire logic telegram_data_input,
    input wire logic power_frequency_input,
    input wire logic cable_cut,
    // tele-powering state
    input wire logic tele_power_ok,
    input wire logic flux_ok,
    input wire logic block_enable,
    // uplink bit stream
    output logic uplink_bit,
    output logic uplink_strobe,
    output logic data_valid,
    output logic default_active,
    // blocking indication toward the encoder
    output logic block_ind
);

    localparam int FW = $clog2(FAIL_CYC + 1);
    localparam int PW = $clog2(POWER_OFF_CYC + 1);
    localparam int VW = $clog2(VALID_CYC + 1);
    localparam int BW = $clog2(BLOCK_CYC + 1);
    localparam int RW = $clog2(RUN_BITS + 1);
    localparam int DW = $clog2(DEF_LEN);
    localparam int OW = 10;
    localparam int DEADLINE = `TDTF_DEADLINE_BITS;
    localparam int RUN_MIN = `TDTF_RUN_MIN;
    localparam int RUN_MAX = `TDTF_RUN_MAX;

    tdtf_pkg::tdtf_state_t state;
    logic bit_tick;
    logic fail_now;
    logic fail_det;
    logic [FW-1:0] fail_cnt;
    logic [PW-1:0] off_cnt;
    logic power_lost;
    logic pwr_prev;
    logic [VW-1:0] flux_cnt;
    logic [BW-1:0] block_cnt;
    logic [RW-1:0] run_cnt;
    logic [DW-1:0] def_idx;
    logic [OW-1:0] onset_bits;

    tdtf_bit_timer #(
        .DIV(BIT_DIV)
    ) u_bit_timer (
        .clk(clk),
        .rst(rst),
        .tick(bit_tick)
    );

    // cut cable, or data at 0 V while the power-frequency line is nominal
    assign fail_now = cable_cut | (~telegram_data_input & power_frequency_input); // [R05]
    assign fail_det = fail_now && (fail_cnt == FW'(FAIL_CYC)); // [R03] [R05]
    assign power_lost = (off_cnt == PW'(POWER_OFF_CYC)); // [R10]

    // failure must stand unbroken before it counts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fail_cnt <= '0;
        end else if (!fail_now) begin
            fail_cnt <= '0;
        end else if (fail_cnt != FW'(FAIL_CYC)) begin
            fail_cnt <= fail_cnt + FW'(1); // [R05]
        end
    end

    // time without tele-powering
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            off_cnt <= '0;
        end else if (tele_power_ok) begin
            off_cnt <= '0;
        end else if (!power_lost) begin
            off_cnt <= off_cnt + PW'(1); // [R10]
        end
    end

    // selection state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= tdtf_pkg::tdtf_st_relay;
            run_cnt <= '0;
            def_idx <= '0;
        end else if (power_lost) begin
            state <= tdtf_pkg::tdtf_st_relay; // [R10]
            run_cnt <= '0;
            def_idx <= '0;
        end else begin
            case (state)
                tdtf_pkg::tdtf_st_relay: begin
                    if (fail_det) begin
                        state <= tdtf_pkg::tdtf_st_run; // [R01]
                        run_cnt <= '0;
                    end
                end
                tdtf_pkg::tdtf_st_run: begin
                    if (bit_tick) begin
                        if (run_cnt == RW'(RUN_BITS - 1)) begin
                            state <= tdtf_pkg::tdtf_st_default; // [R02]
                            def_idx <= '0;
                        end
                        run_cnt <= run_cnt + RW'(1);
                    end
                end
                tdtf_pkg::tdtf_st_default: begin
                    // latched until power loss, input recovery ignored
                    if (bit_tick) begin
                        def_idx <= (def_idx == DW'(DEF_LEN - 1)) ? '0 : def_idx + DW'(1); // [R04]
                    end
                end
                default: begin
                    state <= tdtf_pkg::tdtf_st_relay;
                end
            endcase
        end
    end

    // bit output: relay, equal ones, or stored telegram
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            uplink_bit <= 1'b0;
            uplink_strobe <= 1'b0;
            default_active <= 1'b0;
        end else begin
            uplink_strobe <= bit_tick;
            default_active <= (state == tdtf_pkg::tdtf_st_default);
            if (bit_tick) begin
                case (state)
                    tdtf_pkg::tdtf_st_relay: uplink_bit <= telegram_data_input; // [R08]
                    tdtf_pkg::tdtf_st_run: uplink_bit <= 1'b1; // [R02]
                    tdtf_pkg::tdtf_st_default: uplink_bit <= DEF_TELEGRAM[def_idx]; // [R01]
                    default: uplink_bit <= telegram_data_input;
                endcase
            end
        end
    end

    // blocking at passage start; the encoder holds its telegram meanwhile
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwr_prev <= 1'b0;
            block_cnt <= '0;
            block_ind <= 1'b0;
        end else begin
            pwr_prev <= tele_power_ok;
            if (tele_power_ok && !pwr_prev && block_enable) begin
                block_cnt <= BW'(BLOCK_CYC); // [R06] [R07]
                block_ind <= 1'b1; // [R09]
            end else if (block_cnt != '0 && tele_power_ok) begin
                block_cnt <= block_cnt - BW'(1);
                block_ind <= (block_cnt != BW'(1));
            end else begin
                block_cnt <= '0;
                block_ind <= 1'b0;
            end
        end
    end

    // data guaranteed only after the flux has stood long enough
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flux_cnt <= '0;
            data_valid <= 1'b0;
        end else if (!flux_ok) begin
            flux_cnt <= '0;
            data_valid <= 1'b0;
        end else if (flux_cnt != VW'(VALID_CYC)) begin
            flux_cnt <= flux_cnt + VW'(1);
        end else begin
            data_valid <= 1'b1; // [R09]
        end
    end

    // bits since the failure began, for checking only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            onset_bits <= '0;
        end else if (state == tdtf_pkg::tdtf_st_relay && !fail_now) begin
            onset_bits <= '0;
        end else if (bit_tick && onset_bits != '1) begin
            onset_bits <= onset_bits + OW'(1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_run_start;
        state == tdtf_pkg::tdtf_st_relay && fail_det && !power_lost;
    endsequence

    sequence s_run_end;
        state == tdtf_pkg::tdtf_st_run ##1 state == tdtf_pkg::tdtf_st_default;
    endsequence

    a_fallback_entry: assert property (s_run_start |=> state == tdtf_pkg::tdtf_st_run) // [R01]
        else $error("failure did not start fallback");

    a_run_ones: assert property (state == tdtf_pkg::tdtf_st_run && bit_tick && !power_lost |=> uplink_bit) // [R02]
        else $error("run bit not one");

    // compared as int: the run limit does not fit the width of the run counter
    a_run_length: assert property (s_run_end |-> int'(run_cnt) >= RUN_MIN && int'(run_cnt) <= RUN_MAX) // [R02]
        else $error("equal-bit run length out of range");

    a_run_deadline: assert property (s_run_end |-> onset_bits <= OW'(DEADLINE)) // [R03]
        else $error("equal-bit run ended too late");

    a_default_held: assert property (state == tdtf_pkg::tdtf_st_default && !power_lost // [R04]
        |=> state == tdtf_pkg::tdtf_st_default)
        else $error("default telegram left during passage");

    a_fail_filter: assert property (!fail_now |=> !fail_det) // [R05]
        else $error("failure detected without standing time");

    a_block_start: assert property ($rose(tele_power_ok) && block_enable |=> ##1 block_ind) // [R06]
        else $error("blocking not raised at passage start");

    a_block_relay: assert property (block_ind && state == tdtf_pkg::tdtf_st_relay && bit_tick // [R08]
        && !power_lost && !fail_det |=> uplink_bit == $past(telegram_data_input))
        else $error("relayed bit corrupted during blocking");

    a_valid_delay: assert property ($rose(data_valid) |-> $past(flux_ok) && flux_cnt == VW'(VALID_CYC)) // [R09]
        else $error("data valid before flux delay");

    a_power_clear: assert property (power_lost |=> state == tdtf_pkg::tdtf_st_relay ##1 !default_active) // [R10]
        else $error("power loss did not clear default");

endmodule : tdtf_top

`default_nettype wire

// ===== hdl/tdtf_map.svh
// constants of the telegram fallback block: clock, bit rate and timing figures
// assumes a 25 MHz system clock and the nominal uplink bit rate
`ifndef TDTF_MAP_SVH
`define TDTF_MAP_SVH

// system clock
`define TDTF_CLK_HZ 25000000
`define TDTF_CLK_MHZ 25
// nominal uplink bit rate, bits per second
`define TDTF_BIT_RATE 564480
// bits of the equal-bit run before the default telegram, legal 75..128
`define TDTF_RUN_BITS 80
`define TDTF_RUN_MIN 75
`define TDTF_RUN_MAX 128
// latest end of the run after a stable failure, in uplink bits
`define TDTF_DEADLINE_BITS 341
// failure must stand this long before it counts, microseconds
`define TDTF_FAIL_US 100
// tele-powering absent this long clears the latched default, microseconds
`define TDTF_POWER_OFF_US 5000
// output data correct this long after the operating flux, microseconds
`define TDTF_VALID_US 150
// length of the blocking indication at passage start, microseconds
`define TDTF_BLOCK_US 1000
// length of the stored default telegram, bits
`define TDTF_DEF_LEN 32

`endif

// ===== hdl/tdtf_pkg.sv
// types of the telegram fallback block
// assumes tdtf_map.svh for all figures
`default_nettype none
package tdtf_pkg;

    typedef enum logic [2:0] {
        tdtf_st_relay = 3'h1,
        tdtf_st_run = 3'h2,
        tdtf_st_default = 3'h4
    } tdtf_state_t;

endpackage : tdtf_pkg

`default_nettype wire

// ===== hdl/tdtf_bit_timer.sv
// uplink bit period enable: one-cycle pulse every DIV clocks
// assumes a single clock and an asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none

module tdtf_bit_timer #(
    parameter int DIV = 44
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bit period strobe
    output logic tick
);

    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] count;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (count == LAST);
            if (count == LAST) begin
                count <= '0;
            end else begin
                count <= count + CW'(1);
            end
        end
    end

endmodule : tdtf_bit_timer

`default_nettype wire

// ===== verif/tdtf_encoder_model.sv
// lineside encoder model: streams a repeating telegram onto the wired data input
// assumes the block's uplink strobe paces the bits and reset is active high
`timescale 1ns/1ps
`default_nettype none
module tdtf_encoder_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // from the block
    input wire logic block_ind,
    input wire logic uplink_strobe,
    // scenario control
    input wire logic sel,
    input wire logic fail_zero,
    input wire logic cut,
    // wired data line
    output logic telegram_data_input
);
    logic [3:0] idx;
    logic held_sel;
    logic [15:0] tel;
    // a new telegram is taken only while no blocking is shown
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held_sel <= 1'b0;
        end else if (uplink_strobe && !block_ind) begin
            held_sel <= sel;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idx <= 4'h0;
        end else if (uplink_strobe) begin
            idx <= idx + 4'h1;
        end
    end
    assign tel = held_sel ? 16'h6666 : 16'hA5A5;
    // a cut line floats, shown as a toggling level
    assign telegram_data_input = fail_zero ? 1'b0 : (cut ? idx[0] : tel[idx]);
endmodule : tdtf_encoder_model
`default_nettype wire

// ===== verif/tdtf_top_tb_top.sv
// testbench of the telegram fallback block with an encoder model on the wired input
// assumes shortened timing parameters on the block
`timescale 1ns/1ps
`default_nettype none
module tdtf_top_tb_top;
    localparam logic [31:0] DEF = 32'h5A3C_96E1;
    logic clk, rst, pfi, cable_cut, tele_power_ok, flux_ok, block_enable, sel, fail_zero;
    logic tdi, uplink_bit, uplink_strobe, data_valid, default_active, block_ind;
    int n_errors, num_checks;
    logic b [0:199];
    tdtf_top #(.BIT_DIV(4), .FAIL_CYC(20), .POWER_OFF_CYC(50), .VALID_CYC(30), .BLOCK_CYC(40),
        .DEF_TELEGRAM(DEF)) DUT (.clk(clk), .rst(rst), .telegram_data_input(tdi), .power_frequency_input(pfi),
        .cable_cut(cable_cut), .tele_power_ok(tele_power_ok), .flux_ok(flux_ok), .block_enable(block_enable),
        .uplink_bit(uplink_bit), .uplink_strobe(uplink_strobe), .data_valid(data_valid),
        .default_active(default_active), .block_ind(block_ind));
    tdtf_encoder_model ENC (.clk(clk), .rst(rst), .block_ind(block_ind), .uplink_strobe(uplink_strobe),
        .sel(sel), .fail_zero(fail_zero), .cut(cable_cut), .telegram_data_input(tdi));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %b expected %b", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    task automatic get_bit;
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (uplink_strobe !== 1'b1 && k < 100);
    endtask : get_bit
    task automatic relay(input int n);
        for (int i = 0; i < n; i++) begin
            get_bit();
            check(uplink_bit, tdi);
        end
    endtask : relay
    task automatic passage(input logic blk);
        tele_power_ok = 1'b0;
        block_enable = blk;
        repeat (60) @(negedge clk);
        check(default_active, 1'b0);
        tele_power_ok = 1'b1;
        repeat (3) @(negedge clk);
        check(block_ind, blk);
    endtask : passage
    task automatic t_block;
        passage(1'b1);
        sel = 1'b1;
        relay(6);
        check(block_ind, 1'b1);
        repeat (30) @(negedge clk);
        check(block_ind, 1'b0);
        relay(8);
    endtask : t_block
    task automatic t_quiet;
        pfi = 1'b0;
        fail_zero = 1'b1;
        repeat (100) @(negedge clk);
        check(default_active, 1'b0);
        fail_zero = 1'b0;
        pfi = 1'b1;
        relay(4);
    endtask : t_quiet
    task automatic t_fallback(input logic cut);
        int pos, run;
        logic [31:0] w;
        logic ok;
        pos = -1;
        run = 0;
        ok = 1'b1;
        cable_cut = cut;
        fail_zero = !cut;
        for (int i = 0; i < 200; i++) begin
            get_bit();
            b[i] = uplink_bit;
            if (i == 60) begin
                cable_cut = 1'b0;
                fail_zero = 1'b0;
            end
        end
        for (int i = 0; i < 168 && pos < 0; i++) begin
            for (int j = 0; j < 32; j++) w[j] = b[i + j];
            if (w === DEF) pos = i;
        end
        for (int j = pos - 1; j >= 0 && b[j] === 1'b1; j--) run++;
        for (int j = pos; j < 200 && pos > 0; j++) ok = ok && (b[j] === DEF[(j - pos) % 32]);
        check(pos > 0 && pos <= 341, 1'b1);
        check(run >= 75 && run <= 128, 1'b1);
        check(ok, 1'b1);
        check(default_active, 1'b1);
    endtask : t_fallback
    initial begin
        rst = 1'b1;
        pfi = 1'b1;
        cable_cut = 1'b0;
        tele_power_ok = 1'b1;
        flux_ok = 1'b0;
        block_enable = 1'b0;
        sel = 1'b0;
        fail_zero = 1'b0;
        n_errors = 0;
        num_checks = 0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        flux_ok = 1'b1;
        repeat (10) @(negedge clk);
        check(data_valid, 1'b0);
        repeat (25) @(negedge clk);
        check(data_valid, 1'b1);
        relay(20);
        t_block();
        t_fallback(1'b1);
        passage(1'b0);
        relay(20);
        t_quiet();
        t_fallback(1'b0);
        passage(1'b0);
        relay(20);
        complete_run();
    end
    // cuts a hang short well beyond the few thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule : tdtf_top_tb_top
`default_nettype wire
